// file: design/serial_link_param_config.sv
// Serial link parameter configuration: APB register file, derived link geometry,
// per-lane checksums and sample word assembly for two converters on up to two lanes.
// Assumes one core clock, an APB master and same-clock lane sync status from the framer.
// Summary of operation
// - Quick code 0x11/0x12/0x21/0x22 selects converters and lanes.
// - 11-bit sample sits in a 16-bit word with two spare bits, default zero.
// - Spare tail bits are zeros by default or pseudorandom when enabled.
// - A two-bit field puts one or two control bits in the spare positions.
// - Device, bank and per-lane identifiers are stored and sent in alignment.
// - Frames per multiframe is register value plus one, default 32.
// - Scrambling enabled by default, active only after lane sync completes.
// - Two-bit field picks alignment sequence normal, off or repeated.
// - Resolution fixed at 11, reported as ten in a 4-bit field.
// - Bits per sample fixed at 16, reported as fifteen.
// - Control words per frame per converter fixed at zero, 5-bit field.
// - Lanes, octets, converters and density derived from quick code; samples fixed at zero, 5-bit field.
// - Each lane has its own checksum for the second alignment multiframe.
// - Checksum is modulo 256 sum of the unpacked parameter fields.
// - Lane zero and lane one checksums readable at their own registers.
// - A control bit inverts the serial output data polarity.
// - A two-bit field selects offset binary or two's complement output.
// - Two registers remap converters to lanes.
// - Lane disable bit holds the link in reset while parameters change.
`timescale 1ns/1ns
`default_nettype none
module serial_link_param_config
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// APB slave
	input wire link_cfg_pkg::apb_req_s apb_req,
	output link_cfg_pkg::apb_rsp_s apb_rsp,
	// Framer status and sample path
	input wire logic lane_sync_done,
	input wire logic [1:0] ctrl_bits_in,
	input wire logic [1:0][10:0] adc_sample,
	output logic [1:0][15:0] lane_word,
	// Configuration towards the framer
	output link_cfg_pkg::link_cfg_s link_cfg
);
	import link_cfg_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// Register storage
	logic [7:0] tail_fmt_r, sysref_opt_r, quick_cfg_r, link_ctrl_r, out_pol_r;
	logic [7:0] dev_id_r, bank_id_r, lane0_id_r, lane1_id_r, scr_lanes_r, frames_r;
	logic [7:0] ctrl_res_r, remap_a_r, remap_b_r, fchk0_r, fchk1_r, prdata_nxt;
	logic [31:0] prdata_r;
	logic [7:0] idx;
	logic setup, access, wr, mapped;

	assign idx = apb_req.paddr[9:2];
	assign setup = apb_req.psel && !apb_req.penable;
	assign access = apb_req.psel && apb_req.penable;
	assign wr = access && apb_req.pwrite && mapped;

	// Zero wait states keep the slave simple; reads are staged in the setup cycle
	assign apb_rsp.pready = 1'b1;
	assign apb_rsp.pslverr = access && !mapped;
	assign apb_rsp.prdata = prdata_r;

	////////////////////////////////////////////////////////////////////////////////
	// Derived geometry
	logic l_m1, hd;
	logic [7:0] f_m1, m_m1;
	logic [4:0] s_m1;

	always_comb
	begin
		s_m1 = 5'h00;
		hd = 1'b0;
		case (quick_cfg_r)
			QC_1C1L:
			begin
				l_m1 = 1'b0;
				f_m1 = 8'h01;
				m_m1 = 8'h00;
			end
			QC_1C2L:
			begin
				l_m1 = 1'b1;
				f_m1 = 8'h00;
				m_m1 = 8'h00;
				hd = 1'b1;
			end
			QC_2C1L:
			begin
				l_m1 = 1'b0;
				f_m1 = 8'h03;
				m_m1 = 8'h01;
			end
			default:
			begin
				l_m1 = 1'b1;
				f_m1 = 8'h01;
				m_m1 = 8'h01;
			end
		endcase
	end

	function automatic logic valid_quick(input logic [7:0] code);
		valid_quick = (code == QC_1C1L) || (code == QC_1C2L) || (code == QC_2C1L)
			|| (code == QC_2C2L);
	endfunction : valid_quick

	////////////////////////////////////////////////////////////////////////////////
	// Address decode and read mux
	always_comb
	begin
		mapped = 1'b1;
		prdata_nxt = 8'h00;
		case (idx)
			IDX_TAIL_FMT: prdata_nxt = tail_fmt_r;
			IDX_SYSREF_OPT: prdata_nxt = sysref_opt_r;
			IDX_QUICK_CFG: prdata_nxt = quick_cfg_r;
			IDX_LINK_CTRL: prdata_nxt = link_ctrl_r;
			IDX_OUT_POL: prdata_nxt = out_pol_r;
			IDX_DEV_ID: prdata_nxt = dev_id_r;
			IDX_BANK_ID: prdata_nxt = bank_id_r;
			IDX_LANE0_ID: prdata_nxt = lane0_id_r;
			IDX_LANE1_ID: prdata_nxt = lane1_id_r;
			IDX_SCR_LANES: prdata_nxt = {scr_lanes_r[7:1], l_m1};
			IDX_OCTETS: prdata_nxt = f_m1;
			IDX_FRAMES: prdata_nxt = frames_r;
			IDX_CONVS: prdata_nxt = m_m1;
			IDX_CTRL_RES: prdata_nxt = {ctrl_res_r[7:6], 2'b00, N_M1};
			IDX_SAMP_W: prdata_nxt = {4'h0, NP_M1};
			IDX_SAMPLES: prdata_nxt = {3'b000, s_m1};
			IDX_DENSITY: prdata_nxt = {hd, 2'b00, CF_VAL};
			IDX_FCHK0: prdata_nxt = fchk0_r;
			IDX_FCHK1: prdata_nxt = fchk1_r;
			IDX_REMAP_A: prdata_nxt = remap_a_r;
			IDX_REMAP_B: prdata_nxt = remap_b_r;
			default: mapped = 1'b0;
		endcase
		if (apb_req.paddr[1:0] != 2'b00 || apb_req.paddr[11:10] != 2'b00)
			mapped = 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			prdata_r <= 32'h0000_0000;
		else if (setup)
			prdata_r <= {24'h00_0000, prdata_nxt};
	end

	////////////////////////////////////////////////////////////////////////////////
	// Writable registers
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			tail_fmt_r <= RST_ZERO;
			sysref_opt_r <= RST_ZERO;
			quick_cfg_r <= RST_QUICK;
			link_ctrl_r <= RST_ZERO;
			out_pol_r <= RST_ZERO;
			dev_id_r <= RST_ZERO;
			bank_id_r <= RST_ZERO;
			lane0_id_r <= RST_ZERO;
			lane1_id_r <= RST_LANE1_ID;
			scr_lanes_r <= RST_SCR_LANES;
			frames_r <= RST_FRAMES;
			ctrl_res_r <= RST_ZERO;
			remap_a_r <= RST_ZERO;
			remap_b_r <= RST_REMAP_B;
		end
		else if (wr)
		begin
			case (idx)
				IDX_TAIL_FMT: tail_fmt_r <= apb_req.pwdata[7:0];
				IDX_SYSREF_OPT: sysref_opt_r <= apb_req.pwdata[7:0];
				IDX_QUICK_CFG:
					if (valid_quick(apb_req.pwdata[7:0]))
						quick_cfg_r <= apb_req.pwdata[7:0];
				IDX_LINK_CTRL: link_ctrl_r <= apb_req.pwdata[7:0];
				IDX_OUT_POL: out_pol_r <= apb_req.pwdata[7:0];
				IDX_DEV_ID: dev_id_r <= apb_req.pwdata[7:0];
				IDX_BANK_ID: bank_id_r <= {4'h0, apb_req.pwdata[3:0]};
				IDX_LANE0_ID: lane0_id_r <= {3'b000, apb_req.pwdata[4:0]};
				IDX_LANE1_ID: lane1_id_r <= {3'b000, apb_req.pwdata[4:0]};
				IDX_SCR_LANES: scr_lanes_r <= {apb_req.pwdata[SCR_BIT], 7'h00};
				// Range limits are software's duty; the value is kept as written
				IDX_FRAMES: frames_r <= apb_req.pwdata[7:0];
				IDX_CTRL_RES: ctrl_res_r <= {apb_req.pwdata[7:6], 6'h00};
				IDX_REMAP_A: remap_a_r <= apb_req.pwdata[7:0];
				IDX_REMAP_B: remap_b_r <= apb_req.pwdata[7:0];
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Per-lane checksums, refreshed every cycle so they trail a parameter change by one cycle
	function automatic logic [7:0] fchk(input logic [4:0] lid);
		fchk = dev_id_r + {4'h0, bank_id_r[3:0]} + {3'b000, lid}
			+ {7'h00, scr_lanes_r[SCR_BIT]} + {7'h00, l_m1} + f_m1
			+ {3'b000, frames_r[4:0]} + m_m1 + {6'h00, ctrl_res_r[7:6]}
			+ {4'h0, N_M1} + {5'h00, SUBCLASS_VAL} + {4'h0, NP_M1}
			+ {5'h00, JESDV_VAL} + {3'b000, s_m1} + {7'h00, hd} + {3'b000, CF_VAL};
	endfunction : fchk

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			fchk0_r <= RST_ZERO;
			fchk1_r <= RST_ZERO;
		end
		else
		begin
			fchk0_r <= fchk(lane0_id_r[4:0]);
			fchk1_r <= fchk(lane1_id_r[4:0]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Configuration towards the framer
	logic lane_dis, tail_prn, pol_inv;
	logic [1:0] ctrl_cnt, fmt;

	assign lane_dis = link_ctrl_r[LANE_DIS_BIT];
	assign tail_prn = link_ctrl_r[TAIL_PRN_BIT];
	assign pol_inv = out_pol_r[POL_BIT];
	assign ctrl_cnt = ctrl_res_r[CTRLB_LSB +: 2];
	assign fmt = tail_fmt_r[1:0];

	always_ff @(posedge core_clk)
	begin
		if (rst)
			link_cfg <= '0;
		else
		begin
			link_cfg.lane_dis <= lane_dis;
			link_cfg.scr_active <= scr_lanes_r[SCR_BIT] && lane_sync_done && !lane_dis;
			case (link_ctrl_r[ILAS_LSB +: 2])
				ILAS_OFF: link_cfg.ilas_mode <= ILAS_OFF;
				ILAS_REPEAT: link_cfg.ilas_mode <= ILAS_REPEAT;
				default: link_cfg.ilas_mode <= ILAS_NORMAL;
			endcase
			link_cfg.pol_inv <= pol_inv;
			link_cfg.did <= dev_id_r;
			link_cfg.bid <= bank_id_r[3:0];
			link_cfg.lid0 <= lane0_id_r[4:0];
			link_cfg.lid1 <= lane1_id_r[4:0];
			link_cfg.k_m1 <= frames_r[4:0];
			link_cfg.l_m1 <= l_m1;
			link_cfg.f_m1 <= f_m1;
			link_cfg.m_m1 <= m_m1;
			link_cfg.s_m1 <= s_m1;
			link_cfg.hd <= hd;
			link_cfg.cs <= ctrl_cnt;
			link_cfg.fchk0 <= fchk0_r;
			link_cfg.fchk1 <= fchk1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Sample words: format, spare bits, remap and polarity
	logic [14:0] lfsr_r;
	logic [1:0][15:0] conv_word;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			lfsr_r <= LFSR_SEED;
		else
			lfsr_r <= {lfsr_r[13:0], lfsr_r[14] ^ lfsr_r[13]};
	end

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_conv
			logic [1:0] spare;
			logic [10:0] smp;
			always_comb
			begin
				smp = adc_sample[g];
				if (fmt == FMT_TWOS)
					smp[SAMPLE_W-1] = ~adc_sample[g][SAMPLE_W-1];
				spare = tail_prn ? lfsr_r[2*g +: 2] : 2'b00;
				if (ctrl_cnt == 2'b01)
					spare[1] = ctrl_bits_in[0];
				else if (ctrl_cnt[1])
					spare = ctrl_bits_in;
				conv_word[g] = '0;
				conv_word[g][SAMPLE_LSB +: SAMPLE_W] = smp;
				conv_word[g][SPARE_LSB +: 2] = spare;
			end
			always_ff @(posedge core_clk)
			begin
				if (rst || lane_dis)
					lane_word[g] <= '0;
				else
				begin
					// Each lane picks its converter; polarity flip is applied last
					lane_word[g] <= conv_word[g ? remap_b_r[0] : remap_a_r[0]]
						^ {WORD_W{pol_inv}};
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	property p_quick_ignore;
		wr && idx == IDX_QUICK_CFG && !valid_quick(apb_req.pwdata[7:0]) |=> $stable(quick_cfg_r);
	endproperty
	a_quick_ignore: assert property (p_quick_ignore) else $error("bad quick code stored");

	property p_geometry;
		quick_cfg_r == QC_2C1L |-> f_m1 == 8'h03 && m_m1 == 8'h01 && !l_m1 && !hd;
	endproperty
	a_geometry: assert property (p_geometry) else $error("geometry mismatch");

	property p_scr_gate;
		!lane_sync_done |=> !link_cfg.scr_active;
	endproperty
	a_scr_gate: assert property (p_scr_gate) else $error("scrambling before sync");

	property p_fchk_track;
		$changed(dev_id_r) |=> fchk0_r == $past(fchk0_r) + dev_id_r - $past(dev_id_r, 2)
			|| $changed(bank_id_r) || $changed(lane0_id_r) || $changed(frames_r)
			|| $changed(quick_cfg_r) || $changed(scr_lanes_r) || $changed(ctrl_res_r);
	endproperty
	a_fchk_track: assert property (p_fchk_track) else $error("checksum stale");

	property p_fchk_read;
		access && !apb_req.pwrite && idx == IDX_FCHK1 && $stable(fchk1_r)
			|-> apb_rsp.prdata[7:0] == fchk1_r;
	endproperty
	a_fchk_read: assert property (p_fchk_read) else $error("lane1 checksum read wrong");

	property p_lane_dis;
		lane_dis |=> lane_word == '0 ##0 link_cfg.lane_dis;
	endproperty
	a_lane_dis: assert property (p_lane_dis) else $error("lane not held in reset");

	property p_tail_zero;
		!tail_prn && ctrl_cnt == 2'b00 |-> conv_word[0][SPARE_LSB +: 2] == 2'b00;
	endproperty
	a_tail_zero: assert property (p_tail_zero) else $error("tail bits not zero");

	property p_ilas_off;
		link_ctrl_r[ILAS_LSB +: 2] == ILAS_OFF ##1 $stable(link_ctrl_r)
			|-> link_cfg.ilas_mode == ILAS_OFF;
	endproperty
	a_ilas_off: assert property (p_ilas_off) else $error("alignment mode not applied");

	property p_k_follow;
		wr && idx == IDX_FRAMES |=> ##1 link_cfg.k_m1 == $past(apb_req.pwdata[4:0], 2);
	endproperty
	a_k_follow: assert property (p_k_follow) else $error("frame count not applied");

	property p_polarity;
		!lane_dis && $stable(remap_a_r) && !remap_a_r[0] && pol_inv
			|=> lane_word[0] == ~$past(conv_word[0]);
	endproperty
	a_polarity: assert property (p_polarity) else $error("polarity not inverted");
endmodule : serial_link_param_config
`default_nettype wire

// file: inc/link_cfg_pkg.sv
// Package: register map, field layout, reset values and carrier types of the link configuration.
// Assumes a single core clock and an APB master with 32-bit data.
`default_nettype none
package link_cfg_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_TAIL_FMT = 8'h14;
	localparam logic [7:0] IDX_SYSREF_OPT = 8'h3a;
	localparam logic [7:0] IDX_QUICK_CFG = 8'h5e;
	localparam logic [7:0] IDX_LINK_CTRL = 8'h5f;
	localparam logic [7:0] IDX_OUT_POL = 8'h60;
	localparam logic [7:0] IDX_DEV_ID = 8'h64;
	localparam logic [7:0] IDX_BANK_ID = 8'h65;
	localparam logic [7:0] IDX_LANE0_ID = 8'h67;
	localparam logic [7:0] IDX_LANE1_ID = 8'h68;
	localparam logic [7:0] IDX_SCR_LANES = 8'h6e;
	localparam logic [7:0] IDX_OCTETS = 8'h6f;
	localparam logic [7:0] IDX_FRAMES = 8'h70;
	localparam logic [7:0] IDX_CONVS = 8'h71;
	localparam logic [7:0] IDX_CTRL_RES = 8'h72;
	localparam logic [7:0] IDX_SAMP_W = 8'h73;
	localparam logic [7:0] IDX_SAMPLES = 8'h74;
	localparam logic [7:0] IDX_DENSITY = 8'h75;
	localparam logic [7:0] IDX_FCHK0 = 8'h78;
	localparam logic [7:0] IDX_FCHK1 = 8'h79;
	localparam logic [7:0] IDX_REMAP_A = 8'h82;
	localparam logic [7:0] IDX_REMAP_B = 8'h83;
	// Reset values
	localparam logic [7:0] RST_QUICK = 8'h22;
	localparam logic [7:0] RST_FRAMES = 8'h1f;
	localparam logic [7:0] RST_SCR_LANES = 8'h80;
	localparam logic [7:0] RST_LANE1_ID = 8'h01;
	localparam logic [7:0] RST_REMAP_B = 8'h01;
	localparam logic [7:0] RST_ZERO = 8'h00;
	// Quick configuration codes
	localparam logic [7:0] QC_1C1L = 8'h11;
	localparam logic [7:0] QC_1C2L = 8'h12;
	localparam logic [7:0] QC_2C1L = 8'h21;
	localparam logic [7:0] QC_2C2L = 8'h22;
	// Field positions
	localparam int LANE_DIS_BIT = 0;
	localparam int ILAS_LSB = 2;
	localparam int TAIL_PRN_BIT = 6;
	localparam int SCR_BIT = 7;
	localparam int POL_BIT = 1;
	localparam int CTRLB_LSB = 6;
	localparam int HD_BIT = 7;
	// Fixed link parameters, stored as value minus one where the link expects it
	localparam logic [3:0] N_M1 = 4'ha;
	localparam logic [3:0] NP_M1 = 4'hf;
	localparam logic [4:0] CF_VAL = 5'h00;
	localparam logic [2:0] SUBCLASS_VAL = 3'h0;
	localparam logic [2:0] JESDV_VAL = 3'h1;
	// Sample word layout
	localparam int SAMPLE_W = 11;
	localparam int WORD_W = 16;
	localparam int SAMPLE_LSB = 5;
	localparam int SPARE_LSB = 3;
	localparam logic [14:0] LFSR_SEED = 15'h7fff;
	localparam logic [1:0] FMT_TWOS = 2'b01;
	typedef enum logic [1:0] {
		ILAS_NORMAL = 2'b00,
		ILAS_OFF = 2'b01,
		ILAS_REPEAT = 2'b10
	} ilas_mode_e;
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_s;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_s;
	typedef struct packed {
		logic lane_dis;
		logic scr_active;
		ilas_mode_e ilas_mode;
		logic pol_inv;
		logic [7:0] did;
		logic [3:0] bid;
		logic [4:0] lid0;
		logic [4:0] lid1;
		logic [4:0] k_m1;
		logic l_m1;
		logic [7:0] f_m1;
		logic [7:0] m_m1;
		logic [4:0] s_m1;
		logic hd;
		logic [1:0] cs;
		logic [7:0] fchk0;
		logic [7:0] fchk1;
	} link_cfg_s;
endpackage : link_cfg_pkg
`default_nettype wire

// file: tb/link_rx_model.sv
// Far-side receiver model: reports lane sync once the link has been enabled for a while.
// Assumes same-clock configuration from the block; restarts sync whenever lanes are disabled.
`timescale 1ns/1ns
`default_nettype none
module link_rx_model
#(
	parameter int SYNC_DLY = 8
)
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Configuration seen from the block
	input wire link_cfg_pkg::link_cfg_s link_cfg,
	// Sync status back to the block
	output logic lane_sync_done
);
	import link_cfg_pkg::*;
	logic [7:0] wait_cnt_r;
	////////////////////////////////////////////////////////////////////////////////
	// Held in reset while lanes are disabled, so sync restarts on re-enable
	always_ff @(posedge core_clk)
	begin
		if (rst || link_cfg.lane_dis)
		begin
			wait_cnt_r <= 8'h00;
			lane_sync_done <= 1'b0;
		end
		else if (wait_cnt_r == 8'(SYNC_DLY - 1))
			lane_sync_done <= 1'b1;
		else
			wait_cnt_r <= wait_cnt_r + 8'h01;
	end
endmodule : link_rx_model
`default_nettype wire

// file: tb/serial_link_param_config_tb_top.sv
// Testbench: APB register tests, derived geometry, checksums and sample word path.
// Assumes zero-wait APB slave and the receiver model for lane sync.
`timescale 1ns/1ns
`default_nettype none
module serial_link_param_config_tb_top;
	import link_cfg_pkg::*;
	logic core_clk;
	logic rst;
	apb_req_s req;
	apb_rsp_s apb_rsp;
	logic sync_done;
	logic [1:0] ctrl_bits_in;
	logic [1:0][10:0] smp;
	logic [1:0][15:0] lane_word;
	link_cfg_s link_cfg;
	int fails;
	int cmp_count;
	int k;
	int nz;
	logic [31:0] r;
	logic e;
	logic [7:0] ri[12] = '{IDX_QUICK_CFG, IDX_FRAMES, IDX_SCR_LANES, IDX_OCTETS, IDX_CONVS,
		IDX_CTRL_RES, IDX_SAMP_W, IDX_SAMPLES, IDX_DENSITY, IDX_LANE1_ID, IDX_REMAP_B,
		IDX_LINK_CTRL};
	logic [7:0] rv[12] = '{RST_QUICK, RST_FRAMES, 8'h81, 8'h01, 8'h01, 8'h0a, 8'h0f, 8'h00,
		8'h00, RST_LANE1_ID, RST_REMAP_B, 8'h00};
	logic [7:0] qc[4] = '{QC_1C1L, QC_1C2L, QC_2C1L, QC_2C2L};
	logic [7:0] lt[4] = '{8'h00, 8'h01, 8'h00, 8'h01};
	logic [7:0] ft[4] = '{8'h01, 8'h00, 8'h03, 8'h01};
	logic [7:0] mt[4] = '{8'h00, 8'h00, 8'h01, 8'h01};
	logic [7:0] ht[4] = '{8'h00, 8'h01, 8'h00, 8'h00};
	////////////////////////////////////////////////////////////////////////////////
	serial_link_param_config DUT
	(
		.core_clk(core_clk),
		.rst(rst),
		.apb_req(req),
		.apb_rsp(apb_rsp),
		.lane_sync_done(sync_done),
		.ctrl_bits_in(ctrl_bits_in),
		.adc_sample(smp),
		.lane_word(lane_word),
		.link_cfg(link_cfg)
	);
	link_rx_model #(.SYNC_DLY(8)) rx
	(
		.core_clk(core_clk),
		.rst(rst),
		.link_cfg(link_cfg),
		.lane_sync_done(sync_done)
	);
	always #20 core_clk = ~core_clk;
	////////////////////////////////////////////////////////////////////////////////
	task end_of_test;
		$display("Comparisons %0d, mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// Request held from setup until pready is seen at an access edge
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int i;
		@(posedge core_clk);
		req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
		@(posedge core_clk);
		req.penable <= 1'b1;
		for (i = 0; i < 16; i++)
		begin
			@(posedge core_clk);
			if (apb_rsp.pready === 1'b1)
				break;
		end
		rd = apb_rsp.prdata;
		err = apb_rsp.pslverr;
		req <= '0;
		if (i == 16)
		begin
			fails++;
			end_of_test();
		end
	endtask : apb
	// Settling time covers the two-edge checksum path
	task wr(input logic [7:0] idx, input logic [7:0] d);
		apb(1'b1, {2'b00, idx, 2'b00}, {24'h00_0000, d}, r, e);
		repeat (3) @(posedge core_clk);
	endtask : wr
	task rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] exp);
		apb(1'b0, {2'b00, idx, 2'b00}, 32'h0000_0000, r, e);
		chk(nm, exp, r);
	endtask : rd_chk
	function automatic logic [7:0] fsum(input logic [7:0] lid, l, f, m, hd, scr);
		return 8'h5a + 8'h03 + lid + scr + l + f + 8'h13 + m + 8'h0a + 8'h0f + 8'h01 + hd;
	endfunction : fsum
	function automatic logic [15:0] exp_w(input logic [10:0] s, input logic [1:0] sp,
		input logic tw, input logic inv);
		logic [15:0] w;
		w = {s ^ {tw, 10'h000}, sp, 3'b000};
		return inv ? ~w : w;
	endfunction : exp_w
	task sc(input logic [7:0] fmt, pol, ctl, input logic [1:0] sp, input logic sw);
		wr(IDX_LINK_CTRL, 8'h01);
		wr(IDX_TAIL_FMT, fmt);
		wr(IDX_OUT_POL, pol);
		wr(IDX_CTRL_RES, ctl);
		wr(IDX_LINK_CTRL, 8'h00);
		chk("cs_pol", {ctl[7:6], pol[1]}, {link_cfg.cs, link_cfg.pol_inv});
		chk("lane0", exp_w(smp[sw], sp, fmt == 8'h01, pol[1]), lane_word[0]);
		chk("lane1", exp_w(smp[!sw], sp, fmt == 8'h01, pol[1]), lane_word[1]);
	endtask : sc
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		rst = 1'b1;
		req = '0;
		ctrl_bits_in = 2'b01;
		smp = {11'h6a5, 11'h123};
		fails = 0;
		cmp_count = 0;
		repeat (16) @(posedge core_clk);
		rst <= 1'b0;
		for (k = 0; k < 12; k++)
			rd_chk("reset", ri[k], rv[k]);
		wr(IDX_LINK_CTRL, 8'h01);
		chk("scr_off", 1'b0, link_cfg.scr_active);
		wr(IDX_DEV_ID, 8'h5a);
		wr(IDX_BANK_ID, 8'h03);
		wr(IDX_LANE0_ID, 8'h04);
		wr(IDX_LANE1_ID, 8'h09);
		// Twenty frames: a multiple of 4 that still covers one octet per frame
		wr(IDX_FRAMES, 8'h13);
		chk("did", 8'h5a, link_cfg.did);
		chk("bid", 4'h3, link_cfg.bid);
		chk("lid", {5'h09, 5'h04}, {link_cfg.lid1, link_cfg.lid0});
		chk("k", 5'h13, link_cfg.k_m1);
		for (k = 0; k < 4; k++)
		begin
			wr(IDX_QUICK_CFG, qc[k]);
			chk("geom_cfg", {lt[k][0], ft[k], mt[k], ht[k][0]},
				{link_cfg.l_m1, link_cfg.f_m1, link_cfg.m_m1, link_cfg.hd});
			rd_chk("lanes", IDX_SCR_LANES, 8'h80 | lt[k]);
			rd_chk("octets", IDX_OCTETS, ft[k]);
			rd_chk("convs", IDX_CONVS, mt[k]);
			rd_chk("density", IDX_DENSITY, {ht[k][0], 7'h00});
			rd_chk("fchk0", IDX_FCHK0, fsum(8'h04, lt[k], ft[k], mt[k], ht[k], 8'h01));
			rd_chk("fchk1", IDX_FCHK1, fsum(8'h09, lt[k], ft[k], mt[k], ht[k], 8'h01));
		end
		wr(IDX_QUICK_CFG, 8'h33);
		rd_chk("quick_bad", IDX_QUICK_CFG, QC_2C2L);
		wr(IDX_OCTETS, 8'hff);
		rd_chk("ro_write", IDX_OCTETS, 8'h01);
		apb(1'b0, 12'h004, 32'h0000_0000, r, e);
		chk("unmapped_err", 1'b1, e);
		chk("unmapped_data", 32'h0000_0000, r);
		apb(1'b1, 12'h179, 32'h0000_00ff, r, e);
		chk("misaligned_err", 1'b1, e);
		wr(IDX_LINK_CTRL, 8'h00);
		repeat (12) @(posedge core_clk);
		chk("scr_on", 1'b1, link_cfg.scr_active);
		wr(IDX_LINK_CTRL, 8'h01);
		wr(IDX_SCR_LANES, 8'h00);
		wr(IDX_LINK_CTRL, 8'h00);
		// Sync is back by now, so only the scramble bit can hold this low
		repeat (12) @(posedge core_clk);
		chk("scr_bit", 1'b0, link_cfg.scr_active);
		rd_chk("fchk_scr", IDX_FCHK0, fsum(8'h04, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00));
		chk("fchk_cfg", fsum(8'h04, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00), link_cfg.fchk0);
		chk("fchk1_cfg", fsum(8'h09, 8'h01, 8'h01, 8'h01, 8'h00, 8'h00), link_cfg.fchk1);
		for (k = 3; k >= 0; k--)
		begin
			wr(IDX_LINK_CTRL, 8'(k << 2) | 8'h01);
			chk("ilas", k == 3 ? 2'b00 : 2'(k), link_cfg.ilas_mode);
		end
		wr(IDX_SCR_LANES, 8'h80);
		sc(8'h00, 8'h00, 8'h00, 2'b00, 1'b0);
		sc(8'h01, 8'h00, 8'h00, 2'b00, 1'b0);
		sc(8'h00, 8'h02, 8'h00, 2'b00, 1'b0);
		sc(8'h00, 8'h00, 8'h80, 2'b01, 1'b0);
		sc(8'h00, 8'h00, 8'h40, 2'b10, 1'b0);
		wr(IDX_LINK_CTRL, 8'h01);
		wr(IDX_REMAP_A, 8'h01);
		wr(IDX_REMAP_B, 8'h00);
		sc(8'h00, 8'h00, 8'h00, 2'b00, 1'b1);
		wr(IDX_LINK_CTRL, 8'h41);
		wr(IDX_LINK_CTRL, 8'h40);
		nz = 0;
		for (k = 0; k < 16; k++)
		begin
			@(posedge core_clk);
			if (lane_word[0][4:3] !== 2'b00)
				nz++;
		end
		chk("tail_prn", 1'b1, nz != 0);
		wr(IDX_LINK_CTRL, 8'h01);
		chk("lane_dis", 32'h0000_0000, lane_word);
		chk("lane_dis_cfg", 1'b1, link_cfg.lane_dis);
		end_of_test();
	end
endmodule : serial_link_param_config_tb_top
`default_nettype wire
